// file: rtl/selftest_cfg.svh
`ifndef SELFTEST_CFG_SVH
`define SELFTEST_CFG_SVH
// key storage geometry
`define KEY_SLOTS 16
`define KEY_IDX_W 4
`define KEY_W 256
// known answer check count and index width
`define CHECK_COUNT 9
`define CHECK_IDX_W 4
// slowest answer the datapath may take before a check counts as failed
`define CHECK_TIMEOUT 16'h0400
`define TIMEOUT_W 16
// fifo ownership mask width
`define FIFO_COUNT 8
`define USE_W 3
// reset values and counter steps
`define ZERO_KEY 256'h0
`define ZERO_IDX 4'h0
`define ZERO_TMO 16'h0
`define TMO_STEP 16'h1
`define IDX_STEP 4'h1
`endif

// file: rtl/selftest_pkg.sv
package selftest_pkg;
  // self-test sequencer states
  typedef enum logic [2:0] {
    st_wipe,
    st_issue,
    st_wait,
    st_ready,
    st_locked
  } st_state_t;
endpackage

// file: rtl/key_store_mem.sv
`timescale 1ns/1ns
`include "selftest_cfg.svh"
// key slot memory with registered read; cleared only by writes of zero through the write port
module key_store_mem (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // write port
  input wire logic wr_en,
  input wire logic [`KEY_IDX_W-1:0] wr_idx,
  input wire logic [`KEY_W-1:0] wr_data,
  // read port, internal datapath only
  input wire logic [`KEY_IDX_W-1:0] rd_idx,
  output logic [`KEY_W-1:0] rd_data
);
  // ==========================================
  // storage
  logic [`KEY_W-1:0] mem [`KEY_SLOTS];

  // a write replaces the whole slot, so the old key is gone
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // registered read for the cipher datapath
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= `ZERO_KEY;
    end else begin
      rd_data <= mem[rd_idx];
    end
  end
endmodule

// file: rtl/crypto_selftest_key_zeroize.sv
`timescale 1ns/1ns
`include "selftest_cfg.svh"
module crypto_selftest_key_zeroize
  import selftest_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // module reset event from the host
  input wire logic reset_event,
  // known answer check datapath handshake
  output logic check_start,
  output logic [`CHECK_IDX_W-1:0] check_sel,
  input wire logic check_done,
  input wire logic check_pass,
  // key write path
  input wire logic key_wr,
  input wire logic key_legacy,
  input wire logic [`KEY_IDX_W-1:0] key_idx,
  input wire logic [`KEY_W-1:0] key_data,
  // key read path, host visible
  input wire logic key_rd,
  output logic [`KEY_W-1:0] key_rd_data,
  // datapath key fetch
  input wire logic [`KEY_IDX_W-1:0] use_idx,
  input wire logic use_legacy,
  output logic [`KEY_W-1:0] use_key,
  // fifo writes
  input wire logic [`USE_W-1:0] fifo_sel,
  input wire logic [`FIFO_COUNT-1:0] fifo_assigned,
  input wire logic fifo_wr,
  output logic [`FIFO_COUNT-1:0] fifo_wr_ok,
  // crypto request gating
  input wire logic crypto_req,
  output logic crypto_grant,
  // status
  output logic st_running,
  output logic st_passed,
  output logic st_failed
);
  // ==========================================
  // state
  st_state_t state_reg, state_next;
  logic [`CHECK_IDX_W-1:0] idx_reg; // current check or wipe slot
  logic [`TIMEOUT_W-1:0] tmo_reg; // cycles waited for answer
  logic fail_reg; // any check failed in this run
  logic [`KEY_W-1:0] legacy_reg [`KEY_SLOTS]; // legacy key registers
  logic [`KEY_W-1:0] store_rd;

  // next check index, shared by wipe and test sweeps
  function automatic logic [`CHECK_IDX_W-1:0] bump(input logic [`CHECK_IDX_W-1:0] v);
    bump = v + `IDX_STEP;
  endfunction

  // ==========================================
  // decode
  wire wiping = (state_reg == st_wipe);
  wire last_slot = (idx_reg == `KEY_IDX_W'(`KEY_SLOTS - 1));
  wire last_check = (idx_reg == `CHECK_IDX_W'(`CHECK_COUNT - 1));
  wire timed_out = (tmo_reg == `CHECK_TIMEOUT);
  wire answer = check_done || timed_out;
  wire answer_ok = check_done && check_pass;
  // a host write lands only once released, wipe has priority
  wire host_wr = key_wr && (state_reg == st_ready);
  wire store_wr = wiping || (host_wr && !key_legacy);
  wire [`KEY_IDX_W-1:0] store_idx = wiping ? idx_reg : key_idx;
  wire [`KEY_W-1:0] store_data = wiping ? `ZERO_KEY : key_data;
  wire fifo_ok = fifo_wr && fifo_assigned[fifo_sel] && (state_reg == st_ready);

  // ==========================================
  // sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      st_wipe: begin
        // all slots cleared before any check runs
        if (last_slot) begin
          state_next = st_issue;
        end
      end
      st_issue: begin
        state_next = st_wait;
      end
      st_wait: begin
        if (answer) begin
          if (!last_check) begin
            state_next = st_issue;
          end else if (fail_reg || !answer_ok) begin
            state_next = st_locked;
          end else begin
            state_next = st_ready;
          end
        end
      end
      st_ready: begin
        state_next = st_ready;
      end
      st_locked: begin
        // nothing but a reset leaves here
        state_next = st_locked;
      end
      default: begin
        state_next = st_wipe;
      end
    endcase
    // a reset event restarts from the wipe in any state
    if (reset_event) begin
      state_next = st_wipe;
    end
  end

  // ==========================================
  // sequencer registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= st_wipe;
    end else begin
      state_reg <= state_next;
    end
  end

  // index walks slots in wipe, checks in test
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_reg <= `ZERO_IDX;
    end else if (reset_event || (wiping && last_slot)) begin
      idx_reg <= `ZERO_IDX;
    end else if (wiping || (state_reg == st_wait && answer)) begin
      idx_reg <= bump(idx_reg);
    end
  end

  // answer timeout; a silent datapath counts as a failure
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmo_reg <= `ZERO_TMO;
    end else if (state_reg == st_wait && !answer) begin
      tmo_reg <= tmo_reg + `TMO_STEP;
    end else begin
      tmo_reg <= `ZERO_TMO;
    end
  end

  // failures accumulate, judged only at the end of the run
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_reg <= 1'b0;
    end else if (wiping) begin
      fail_reg <= 1'b0;
    end else if (state_reg == st_wait && answer && !answer_ok) begin
      fail_reg <= 1'b1;
    end
  end

  // ==========================================
  // legacy key registers, cleared alongside the store
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `KEY_SLOTS; i++) begin
        legacy_reg[i] <= `ZERO_KEY;
      end
    end else if (wiping) begin
      legacy_reg[idx_reg] <= `ZERO_KEY;
    end else if (host_wr && key_legacy) begin
      legacy_reg[key_idx] <= key_data;
    end
  end

  key_store_mem u_store (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wr_en(store_wr),
    .wr_idx(store_idx),
    .wr_data(store_data),
    .rd_idx(use_idx),
    .rd_data(store_rd)
  );

  // ==========================================
  // outputs, all registered
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      check_start <= 1'b0;
      check_sel <= `ZERO_IDX;
      key_rd_data <= `ZERO_KEY;
      use_key <= `ZERO_KEY;
      fifo_wr_ok <= '0;
      crypto_grant <= 1'b0;
      st_running <= 1'b0;
      st_passed <= 1'b0;
      st_failed <= 1'b0;
    end else begin
      check_start <= (state_next == st_issue);
      check_sel <= (state_next == st_issue && state_reg == st_wait) ? bump(idx_reg) :
        ((state_next == st_issue) ? `ZERO_IDX : check_sel);
      // host reads of key storage never see the secret_parameter
      key_rd_data <= `ZERO_KEY;
      // stored key two cycles behind use_idx, legacy key one cycle behind
      use_key <= use_legacy ? legacy_reg[use_idx] : store_rd;
      fifo_wr_ok <= fifo_ok ? (`FIFO_COUNT'(1) << fifo_sel) : '0;
      crypto_grant <= crypto_req && (state_next == st_ready);
      st_running <= (state_next == st_wipe || state_next == st_issue || state_next == st_wait);
      st_passed <= (state_next == st_ready);
      st_failed <= (state_next == st_locked);
    end
  end
endmodule

// file: bench/crypto_selftest_key_zeroize_properties.sv
`timescale 1ns/1ns
// ==========
// sequencer and gating properties
module selftest_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // sequencing
  input wire logic reset_event,
  input wire logic check_start,
  input wire logic [3:0] check_sel,
  input wire logic check_done,
  input wire logic check_pass,
  // gated requests
  input wire logic crypto_req,
  input wire logic crypto_grant,
  input wire logic [2:0] fifo_sel,
  input wire logic [7:0] fifo_assigned,
  input wire logic fifo_wr,
  input wire logic [7:0] fifo_wr_ok,
  // status
  input wire logic st_running,
  input wire logic st_passed,
  input wire logic st_failed
);
  // a write that must reach its fifo
  wire fifo_hit = fifo_wr && st_passed && fifo_assigned[fifo_sel];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // grant follows a request by one cycle, and only while released
  a_grant_gate: assert property (crypto_grant == ($past(crypto_req) && st_passed))
    else $error("grant without ready request");
  a_status_onehot: assert property ($past(rst_n) |-> $onehot({st_running, st_passed, st_failed}))
    else $error("status not one-hot");
  a_event_rerun: assert property (reset_event |=> st_running)
    else $error("reset event did not rerun");
  a_lock_holds: assert property (st_failed && !reset_event |=> st_failed)
    else $error("lock left without reset");
  a_fifo_gate: assert property (fifo_wr_ok == ($past(fifo_hit) ? 8'h01 << $past(fifo_sel) : 8'h00))
    else $error("fifo write gating wrong");
  a_start_pulse: assert property (check_start |=> !check_start)
    else $error("start longer than one cycle");
  a_next_check: assert property (check_done && st_running && !reset_event && check_sel != 4'h8
    |=> check_start && check_sel == $past(check_sel) + 4'h1)
    else $error("next check not started");
  a_last_fail: assert property (check_done && st_running && !check_pass && !reset_event
    && check_sel == 4'h8 |=> st_failed)
    else $error("failed check did not lock");
endmodule

bind crypto_selftest_key_zeroize selftest_props i_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .reset_event(reset_event), .check_start(check_start), .check_sel(check_sel), .check_done(check_done),
  .check_pass(check_pass), .crypto_req(crypto_req), .crypto_grant(crypto_grant), .fifo_sel(fifo_sel),
  .fifo_assigned(fifo_assigned), .fifo_wr(fifo_wr), .fifo_wr_ok(fifo_wr_ok), .st_running(st_running),
  .st_passed(st_passed), .st_failed(st_failed));

// file: bench/crypto_selftest_key_zeroize_tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("BAD %0t %h %h", $time, g, e); end end
module crypto_selftest_key_zeroize_tb;
  // ==========
  // stimulus and observed signals
  logic sys_clk = 0, rst_n = 0, reset_event = 0, check_done = 0, check_pass = 0;
  logic key_wr = 0, key_legacy = 0, key_rd = 0, use_legacy = 0, fifo_wr = 0, crypto_req = 0;
  logic [3:0] key_idx = 0, use_idx = 0, fail_sel = 4'hf, mute_sel = 4'hf, nsel = 0, cur = 0, check_sel;
  logic [2:0] fifo_sel = 0;
  logic [7:0] fifo_assigned = 0, fifo_wr_ok;
  logic [255:0] key_data = 0, key_rd_data, use_key, k;
  logic check_start, crypto_grant, st_running, st_passed, st_failed;
  logic [8:0] exp_q[$], exp_v;
  int mismatches = 0, n_checks = 0, dly = 0;
  always #2 sys_clk = ~sys_clk;
  crypto_selftest_key_zeroize i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .reset_event(reset_event),
    .check_start(check_start), .check_sel(check_sel), .check_done(check_done), .check_pass(check_pass),
    .key_wr(key_wr), .key_legacy(key_legacy), .key_idx(key_idx), .key_data(key_data),
    .key_rd(key_rd), .key_rd_data(key_rd_data),
    .use_idx(use_idx), .use_legacy(use_legacy), .use_key(use_key),
    .fifo_sel(fifo_sel), .fifo_assigned(fifo_assigned), .fifo_wr(fifo_wr), .fifo_wr_ok(fifo_wr_ok),
    .crypto_req(crypto_req), .crypto_grant(crypto_grant),
    .st_running(st_running), .st_passed(st_passed), .st_failed(st_failed)
  );
  // ==========
  // datapath stand-in, answers 1..4 cycles after start
  always @(posedge sys_clk) begin
    check_done <= 1'b0;
    if (!rst_n || reset_event) begin
      // a restart drops whatever answer was still due
      nsel = 4'h0;
      dly = 0;
    end else if (check_start) begin
      `CHK(check_sel, nsel)
      nsel = nsel + 4'h1;
      cur = check_sel;
      dly = 1 + $urandom % 4;
    end else if (dly > 0) begin
      dly--;
      // only the commanded check answers wrongly, a muted one never answers
      if (dly == 0 && cur != mute_sel) begin
        check_done <= 1'b1;
        check_pass <= cur != fail_sel;
      end
    end
  end
  // result watcher, grant and fifo pulses
  always @(posedge sys_clk) begin
    if (crypto_grant || fifo_wr_ok != 8'h0) begin
      exp_v = exp_q.size() > 0 ? exp_q.pop_front() : 9'h0;
      `CHK({crypto_grant, fifo_wr_ok}, exp_v)
    end
  end
  // ==========
  // tasks
  task wait_done(input logic [3:0] f);
    // long enough for a run that waits out one answer timeout
    for (int i = 0; i < 2000 && st_running !== 1'b0; i++) @(posedge sys_clk);
    `CHK({st_passed, st_failed}, f > 4'h8 ? 2'h2 : 2'h1)
  endtask
  // host reset event; stale answers dropped
  task boot(input logic [3:0] f);
    fail_sel = f;
    reset_event <= 1'b1;
    @(posedge sys_clk);
    reset_event <= 1'b0;
    @(posedge sys_clk);
    `CHK(st_running, 1'b1)
    wait_done(f);
  endtask
  // write, overwrite, fetch; wiped keys read zero
  task keys(input logic wipe);
    for (int l = 0; l < 2; l++) begin
      k = {8{$urandom}};
      key_legacy <= l[0];
      key_idx <= 4'h3;
      key_data <= ~k;
      // a locked engine is offered the write and must refuse it
      key_wr <= !wipe || st_failed;
      @(posedge sys_clk);
      key_data <= k;
      @(posedge sys_clk);
      key_wr <= 1'b0;
      use_legacy <= l[0];
      use_idx <= 4'h3;
      key_rd <= 1'b1;
      repeat (3) @(posedge sys_clk);
      `CHK(use_key, wipe ? 256'h0 : k)
      `CHK(key_rd_data, 256'h0)
    end
  endtask
  // random requests, far below any key-usage limit
  task traffic();
    logic [2:0] s;
    logic [7:0] a;
    logic w, r;
    for (int i = 0; i < 24; i++) begin
      s = $urandom;
      a = $urandom;
      w = $urandom;
      r = $urandom;
      fifo_sel <= s;
      fifo_assigned <= a;
      fifo_wr <= w;
      crypto_req <= r;
      if (st_passed && (r || (w && a[s]))) exp_q.push_back({r, w && a[s] ? 8'h01 << s : 8'h0});
      @(posedge sys_clk);
    end
    fifo_wr <= 1'b0;
    crypto_req <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  task give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========
  // main sequence
  initial begin
    void'($urandom(32'he0c2));
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    `CHK(st_running, 1'b1)
    wait_done(4'hf);
    keys(1'b0);
    traffic();
    boot(4'hf);
    keys(1'b1);
    boot(4'($urandom % 9));
    traffic();
    keys(1'b1);
    boot(4'h8);
    boot(4'hf);
    traffic();
    keys(1'b0);
    // power cycle after a passed run; the new run must find no key left
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    `CHK(st_running, 1'b1)
    wait_done(4'hf);
    keys(1'b1);
    // a reset event while released after a passed run restarts the checks
    reset_event <= 1'b1;
    @(posedge sys_clk);
    reset_event <= 1'b0;
    repeat (30) @(posedge sys_clk);
    `CHK(st_running, 1'b1)
    boot(4'hf);
    // a check that never answers must still end in the lock
    mute_sel = 4'h2;
    boot(4'h2);
    mute_sel = 4'hf;
    `CHK(exp_q.size(), 0)
    give_verdict();
  end
  // hang guard
  initial begin
    #60000;
    mismatches++;
    give_verdict();
  end
endmodule
